//--- logic/dlet_core.sv
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "dlet_cfg.svh"
// Summary of operation
// - Exhausted set reloads from its link address
// - Static bit set blocks any link update
// - Link only after last request submitted, or at once for a null set
// - Null link writes zero set, link FFFFh
// - Link copies all eight words
// - Any set may serve as link source
// - Link into quick set latches quick event
// - Self link repeats same parameters
// - No alignment check in constant mode
// - Transfers described by three counts only
// - Write 1 to event set triggers channel
// - Completion code chains to another channel
// - Quick trigger by word write or link
// - Peripheral event latches regardless of enable
// - Enabled latched events enter the queue
// - Valid set submits request, clears event
// - Null set: no request, clear, flag missed
// - Disabled pending event served once enabled
// - Second event while pending flags missed
// - Audio events on fixed channels 10-15
// - All three counts zero means null set
module dlet_core #(
    parameter int NSETS = 512,
    parameter int QDEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [15:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Synchronisation events
    input wire logic [63:0] periphEvent,
    input wire logic audio_tx_even_event,
    input wire logic audio_tx_odd_event,
    input wire logic audio_tx_both_event,
    input wire logic audio_rx_even_event,
    input wire logic audio_rx_odd_event,
    input wire logic audio_rx_both_event,
    // Completion codes from the transfer controller
    input wire logic tcDone,
    input wire logic [5:0] tcCode,
    // Transfer request packets
    output logic trpValid,
    input wire logic trpReady,
    output dlet_pkg::dlet_trp_s transfer_request_packet
);
    localparam int SW = $clog2(NSETS);
    localparam int MW = SW + 3;
    localparam int QW = $clog2(QDEPTH);
    localparam int NQ = `DLET_NQ;

    logic [31:0] mem [0:NSETS*8-1];
    logic [63:0] latch_reg, enable_reg, missed_reg, manual_reg, queued_reg;
    logic [NQ-1:0] qLatch_reg, qEnable_reg, qMissed_reg, qQueued_reg;
    logic [31:0] qmap_reg [NQ];
    logic [6:0] fifo [QDEPTH];
    logic [QW:0] qCount_reg;
    logic [QW-1:0] wrPtr_reg, rdPtr_reg;
    dlet_pkg::dlet_state_e state_reg;
    logic [6:0] curCh_reg;
    logic [SW-1:0] curSet_reg, linkSrc_reg;
    logic [2:0] idx_reg;
    logic linkNull_reg, static_reg, exhaust_reg;

    // Bus decode
    logic busReq, fsmWe, busWr, memHit;
    logic [31:0] mask, busRd;
    logic [MW-1:0] busMemAdr;
    assign busReq = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign busWr = busReq && wb_we_i && !fsmWe;
    assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                   {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign busMemAdr = wb_adr_i[2 +: MW];
    assign memHit = (wb_adr_i[15:14] == `DLET_A_PMEM_TOP) &&
                    (int'(wb_adr_i[13:2]) < NSETS * 8);

    function automatic logic [31:0] wm(input logic [31:0] old);
        wm = (old & ~mask) | (wb_dat_i & mask);
    endfunction

    function automatic logic [63:0] hit64(input logic [15:0] lo,
                                          input logic [15:0] hi);
        hit64 = 64'h0;
        if (busWr && wb_adr_i == lo) begin
            hit64[31:0] = wb_dat_i & mask;
        end else if (busWr && wb_adr_i == hi) begin
            hit64[63:32] = wb_dat_i & mask;
        end
    endfunction

    // Current set words
    logic [31:0] wOpt, wCnt, wLink, wCcnt;
    logic [15:0] bytes_per_array, arrays_per_frame, frames_per_block, bRld;
    logic isNull, isStatic, isAb, exhausted;
    assign wOpt = mem[{curSet_reg, `DLET_W_OPT}];
    assign wCnt = mem[{curSet_reg, `DLET_W_CNT}];
    assign wLink = mem[{curSet_reg, `DLET_W_LINK}];
    assign wCcnt = mem[{curSet_reg, `DLET_W_FRAMES_PER_BLOCK}];
    assign bytes_per_array = wCnt[15:0];
    assign arrays_per_frame = wCnt[31:16];
    assign bRld = wLink[31:16];
    assign frames_per_block = wCcnt[15:0];
    assign isNull = bytes_per_array == 16'h0 && arrays_per_frame == 16'h0 && frames_per_block == 16'h0;
    assign isStatic = wOpt[`DLET_OPT_STATIC];
    assign isAb = wOpt[`DLET_OPT_AB];
    // Null and dummy sets count as exhausted so their link still runs
    assign exhausted = bytes_per_array == 16'h0 || arrays_per_frame == 16'h0 || frames_per_block == 16'h0 ||
        (isAb ? frames_per_block == 16'h1 : (arrays_per_frame == 16'h1 && frames_per_block == 16'h1));

    // Parameter memory writes from the engine
    logic [MW-1:0] fsmAdr;
    logic [31:0] fsmData;
    logic isEval, linkLast;
    assign isEval = state_reg == dlet_pkg::S_EVAL;
    assign linkLast = state_reg == dlet_pkg::S_LINK && idx_reg == `DLET_W_LAST;
    always_comb begin
        fsmWe = 1'b0;
        fsmAdr = {curSet_reg, idx_reg};
        fsmData = 32'h0;
        if (state_reg == dlet_pkg::S_LINK) begin
            fsmWe = 1'b1;
            if (linkNull_reg) begin
                fsmData = (idx_reg == `DLET_W_LINK) ?
                          `DLET_NULL_LINK_WORD : 32'h0;
            end else begin
                fsmData = mem[{linkSrc_reg, idx_reg}];
            end
        end else if (state_reg == dlet_pkg::S_UPDATE) begin
            fsmWe = 1'b1;
            if (idx_reg == `DLET_W_CNT) begin
                fsmData = wCnt;
                if (!isAb) begin
                    fsmData[31:16] = (arrays_per_frame > 16'h1) ? arrays_per_frame - 16'h1 : bRld;
                end
            end else begin
                fsmData = wCcnt;
                if (isAb || arrays_per_frame == 16'h1) begin
                    fsmData[15:0] = frames_per_block - 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (fsmWe) begin
            mem[fsmAdr] <= fsmData;
        end else if (busWr && memHit) begin
            mem[busMemAdr] <= wm(mem[busMemAdr]);
        end
    end

    // Event sources
    logic [63:0] extEv, setEv, chainEv, newEv, svcClr, nullMiss;
    always_comb begin
        extEv = periphEvent;
        extEv[`DLET_CH_ATXE] = periphEvent[`DLET_CH_ATXE] |
                               audio_tx_even_event;
        extEv[`DLET_CH_ATXO] = periphEvent[`DLET_CH_ATXO] |
                               audio_tx_odd_event;
        extEv[`DLET_CH_ATXB] = periphEvent[`DLET_CH_ATXB] |
                               audio_tx_both_event;
        extEv[`DLET_CH_ARXE] = periphEvent[`DLET_CH_ARXE] |
                               audio_rx_even_event;
        extEv[`DLET_CH_ARXO] = periphEvent[`DLET_CH_ARXO] |
                               audio_rx_odd_event;
        extEv[`DLET_CH_ARXB] = periphEvent[`DLET_CH_ARXB] |
                               audio_rx_both_event;
    end
    assign setEv = hit64(`DLET_A_SET_LO, `DLET_A_SET_HI);
    assign chainEv = tcDone ? (64'h1 << tcCode) : 64'h0;
    assign newEv = extEv | setEv | chainEv;
    assign svcClr = (isEval && !curCh_reg[6]) ?
                    (64'h1 << curCh_reg[5:0]) : 64'h0;
    assign nullMiss = isNull ? svcClr : 64'h0;

    // Quick channel triggers
    logic [NQ-1:0] qTrig, qSvcClr;
    always_comb begin
        for (int q = 0; q < NQ; q++) begin
            qTrig[q] = qEnable_reg[q] && (
                (busWr && memHit && busMemAdr ==
                 {qmap_reg[q][`DLET_QMAP_SET_LSB +: SW],
                  qmap_reg[q][`DLET_QMAP_WORD_LSB +: 3]}) ||
                (linkLast &&
                 qmap_reg[q][`DLET_QMAP_SET_LSB +: SW] == curSet_reg));
            qSvcClr[q] = isEval && curCh_reg == `DLET_QBASE + 7'(q);
        end
    end

    // Event latch, enable, missed
    always_ff @(posedge clk) begin
        if (!resetn) begin
            latch_reg <= 64'h0;
            manual_reg <= 64'h0;
            enable_reg <= 64'h0;
            missed_reg <= 64'h0;
        end else begin
            // A new event wins over a clear in the same cycle
            latch_reg <= (latch_reg & ~svcClr &
                ~hit64(`DLET_A_LAT_LO, `DLET_A_LAT_HI)) | newEv;
            manual_reg <= (manual_reg & ~svcClr) | setEv;
            missed_reg <= (missed_reg &
                ~hit64(`DLET_A_MIS_LO, `DLET_A_MIS_HI)) |
                (newEv & latch_reg) | nullMiss;
            if (busWr && wb_adr_i == `DLET_A_ENA_LO) begin
                enable_reg[31:0] <= wm(enable_reg[31:0]);
            end else if (busWr && wb_adr_i == `DLET_A_ENA_HI) begin
                enable_reg[63:32] <= wm(enable_reg[63:32]);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            qLatch_reg <= '0;
            qMissed_reg <= '0;
            qEnable_reg <= '0;
        end else begin
            qLatch_reg <= (qLatch_reg & ~qSvcClr) | qTrig;
            qMissed_reg <= (qMissed_reg &
                ~((busWr && wb_adr_i == `DLET_A_QMIS) ?
                  NQ'(wb_dat_i & mask) : '0)) |
                (qTrig & qLatch_reg) | (isNull ? qSvcClr : '0);
            if (busWr && wb_adr_i == `DLET_A_QENA) begin
                qEnable_reg <= NQ'(wm(32'(qEnable_reg)));
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int q = 0; q < NQ; q++) begin
                qmap_reg[q] <= 32'h0;
            end
        end else begin
            for (int q = 0; q < NQ; q++) begin
                if (busWr && wb_adr_i == `DLET_A_QMAP_MSB + 16'(4 * q)) begin
                    qmap_reg[q] <= wm(qmap_reg[q]);
                end
            end
        end
    end

    // Prioritise: lowest pending channel number enters the queue first
    logic [63:0] pend;
    logic [NQ-1:0] qPend;
    logic pushOk, popOk;
    logic [6:0] pushId;
    assign pend = latch_reg & (enable_reg | manual_reg) & ~queued_reg;
    assign qPend = qLatch_reg & ~qQueued_reg;
    always_comb begin
        pushId = 7'h0;
        for (int i = `DLET_NCH + NQ - 1; i >= 0; i--) begin
            if (i < `DLET_NCH ? pend[i] : qPend[i - `DLET_NCH]) begin
                pushId = 7'(i);
            end
        end
    end
    assign pushOk = (|pend || |qPend) && qCount_reg != (QW+1)'(QDEPTH);
    assign popOk = state_reg == dlet_pkg::S_IDLE && qCount_reg != '0;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            queued_reg <= 64'h0;
            qQueued_reg <= '0;
        end else begin
            queued_reg <= (queued_reg & ~svcClr) |
                ((pushOk && !pushId[6]) ? 64'h1 << pushId[5:0] : 64'h0);
            qQueued_reg <= (qQueued_reg & ~qSvcClr) |
                ((pushOk && pushId[6]) ? NQ'(1) << pushId[2:0] : '0);
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            qCount_reg <= '0;
        end else begin
            if (pushOk) begin
                fifo[wrPtr_reg] <= pushId;
                wrPtr_reg <= wrPtr_reg + 1'b1;
            end
            if (popOk) begin
                rdPtr_reg <= rdPtr_reg + 1'b1;
            end
            qCount_reg <= qCount_reg + (QW+1)'(pushOk) - (QW+1)'(popOk);
        end
    end

    // Service engine
    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= dlet_pkg::S_IDLE;
            curCh_reg <= 7'h0;
            curSet_reg <= '0;
            linkSrc_reg <= '0;
            idx_reg <= 3'h0;
            linkNull_reg <= 1'b0;
            static_reg <= 1'b0;
            exhaust_reg <= 1'b0;
            trpValid <= 1'b0;
            transfer_request_packet <= '0;
        end else begin
            case (state_reg)
                dlet_pkg::S_IDLE: begin
                    if (popOk) begin
                        curCh_reg <= fifo[rdPtr_reg];
                        curSet_reg <= fifo[rdPtr_reg][6] ?
                            qmap_reg[fifo[rdPtr_reg][2:0]]
                                [`DLET_QMAP_SET_LSB +: SW] :
                            SW'(fifo[rdPtr_reg][5:0]);
                        state_reg <= dlet_pkg::S_EVAL;
                    end
                end
                dlet_pkg::S_EVAL: begin
                    // Upper link bits are ignored; no alignment check
                    linkSrc_reg <= wLink[`DLET_LINK_SET_LSB +: SW];
                    linkNull_reg <= wLink[15:0] == `DLET_LINK_NULL;
                    static_reg <= isStatic;
                    exhaust_reg <= exhausted;
                    idx_reg <= 3'h0;
                    if (isNull) begin
                        state_reg <= isStatic ? dlet_pkg::S_IDLE :
                                     dlet_pkg::S_LINK;
                    end else begin
                        trpValid <= 1'b1;
                        transfer_request_packet.channel <= curCh_reg;
                        transfer_request_packet.setIndex <= 16'(curSet_reg);
                        transfer_request_packet.option <= wOpt;
                        transfer_request_packet.src <= mem[{curSet_reg, `DLET_W_SRC}];
                        transfer_request_packet.dst <= mem[{curSet_reg, `DLET_W_DST}];
                        transfer_request_packet.bytesPerArray <= bytes_per_array;
                        transfer_request_packet.arraysPerFrame <= isAb ? arrays_per_frame : 16'h1;
                        transfer_request_packet.framesPerBlock <= 16'h1;
                        state_reg <= dlet_pkg::S_SUBMIT;
                    end
                end
                dlet_pkg::S_SUBMIT: begin
                    if (trpReady) begin
                        trpValid <= 1'b0;
                        idx_reg <= exhaust_reg ? 3'h0 : `DLET_W_FRAMES_PER_BLOCK;
                        if (!exhaust_reg) begin
                            state_reg <= dlet_pkg::S_UPDATE;
                        end else if (static_reg) begin
                            state_reg <= dlet_pkg::S_IDLE;
                        end else begin
                            state_reg <= dlet_pkg::S_LINK;
                        end
                    end
                end
                dlet_pkg::S_UPDATE: begin
                    // Frame count first, so its test sees the old array count
                    idx_reg <= `DLET_W_CNT;
                    if (idx_reg == `DLET_W_CNT) begin
                        state_reg <= dlet_pkg::S_IDLE;
                    end
                end
                dlet_pkg::S_LINK: begin
                    idx_reg <= idx_reg + 3'h1;
                    if (idx_reg == `DLET_W_LAST) begin
                        state_reg <= dlet_pkg::S_IDLE;
                    end
                end
                default: state_reg <= dlet_pkg::S_IDLE;
            endcase
        end
    end

    // Register read mux
    always_comb begin
        busRd = 32'h0;
        if (memHit) begin
            busRd = mem[busMemAdr];
        end else if (wb_adr_i == `DLET_A_LAT_LO) begin
            busRd = latch_reg[31:0];
        end else if (wb_adr_i == `DLET_A_LAT_HI) begin
            busRd = latch_reg[63:32];
        end else if (wb_adr_i == `DLET_A_ENA_LO) begin
            busRd = enable_reg[31:0];
        end else if (wb_adr_i == `DLET_A_ENA_HI) begin
            busRd = enable_reg[63:32];
        end else if (wb_adr_i == `DLET_A_MIS_LO) begin
            busRd = missed_reg[31:0];
        end else if (wb_adr_i == `DLET_A_MIS_HI) begin
            busRd = missed_reg[63:32];
        end else if (wb_adr_i == `DLET_A_QLAT) begin
            busRd = 32'(qLatch_reg);
        end else if (wb_adr_i == `DLET_A_QENA) begin
            busRd = 32'(qEnable_reg);
        end else if (wb_adr_i == `DLET_A_QMIS) begin
            busRd = 32'(qMissed_reg);
        end else if (wb_adr_i == `DLET_A_STAT) begin
            busRd = {16'(qCount_reg), 11'h0, state_reg};
        end else if (wb_adr_i[15:5] == `DLET_A_QMAP_MSB >> 5) begin
            busRd = qmap_reg[wb_adr_i[4:2]];
        end
    end

    // Engine memory writes take the port, so the bus waits until they end, up to eight cycles
    always_ff @(posedge clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= busReq && !fsmWe;
            if (busReq && !fsmWe && !wb_we_i) begin
                wb_dat_o <= busRd;
            end
        end
    end

    // Checks
    property p_null_missed;
        @(posedge clk) disable iff (!resetn)
        isEval && isNull && !curCh_reg[6] |=> |(missed_reg & $past(svcClr));
    endproperty
    a_null_missed: assert property (p_null_missed)
        else $error("null set did not flag missed");
    property p_null_nosub;
        @(posedge clk) disable iff (!resetn)
        isEval && isNull |=> !trpValid;
    endproperty
    a_null_nosub: assert property (p_null_nosub)
        else $error("null set produced a request");
    property p_valid_submit;
        @(posedge clk) disable iff (!resetn)
        isEval && !isNull |=> trpValid && transfer_request_packet.channel == $past(curCh_reg);
    endproperty
    a_valid_submit: assert property (p_valid_submit)
        else $error("valid set not submitted");
    property p_static_nolink;
        @(posedge clk) disable iff (!resetn)
        state_reg == dlet_pkg::S_LINK |-> !static_reg && exhaust_reg;
    endproperty
    a_static_nolink: assert property (p_static_nolink)
        else $error("link ran on static or unexhausted set");
    property p_link_eight;
        @(posedge clk) disable iff (!resetn)
        $rose(state_reg == dlet_pkg::S_LINK) |->
            (state_reg == dlet_pkg::S_LINK)[*8] ##1
            state_reg == dlet_pkg::S_IDLE;
    endproperty
    a_link_eight: assert property (p_link_eight)
        else $error("link copy not eight words");
    property p_null_link;
        @(posedge clk) disable iff (!resetn)
        state_reg == dlet_pkg::S_LINK && linkNull_reg |->
            fsmData == (idx_reg == `DLET_W_LINK ? `DLET_NULL_LINK_WORD : 0);
    endproperty
    a_null_link: assert property (p_null_link)
        else $error("null link wrote wrong word");
    property p_missed_event;
        @(posedge clk) disable iff (!resetn)
        |(newEv & latch_reg) |=> |(missed_reg & $past(newEv & latch_reg));
    endproperty
    a_missed_event: assert property (p_missed_event)
        else $error("second event not flagged missed");
    property p_event_latch;
        @(posedge clk) disable iff (!resetn)
        |extEv |=> (latch_reg & $past(extEv)) == $past(extEv);
    endproperty
    a_event_latch: assert property (p_event_latch)
        else $error("event not latched");
    property p_quick_link;
        @(posedge clk) disable iff (!resetn)
        |qTrig |=> (qLatch_reg & $past(qTrig)) == $past(qTrig);
    endproperty
    a_quick_link: assert property (p_quick_link)
        else $error("quick trigger not latched");
    c_null: cover property (@(posedge clk) isEval && isNull);
    c_link: cover property (@(posedge clk) linkLast && !linkNull_reg);
    c_quick: cover property (@(posedge clk) linkLast && |qTrig);
endmodule

//--- logic/dlet_cfg.svh
`ifndef DLET_CFG_SVH
`define DLET_CFG_SVH
// Channel counts
`define DLET_NCH 64
`define DLET_NQ 8
`define DLET_QBASE 7'h40
// Parameter set words
`define DLET_W_OPT 3'h0
`define DLET_W_SRC 3'h1
`define DLET_W_CNT 3'h2
`define DLET_W_DST 3'h3
`define DLET_W_B_DIMENSION_INDEX 3'h4
`define DLET_W_LINK 3'h5
`define DLET_W_CIDX 3'h6
`define DLET_W_FRAMES_PER_BLOCK 3'h7
`define DLET_W_LAST 3'h7
// Option word bits
`define DLET_OPT_SAM 0
`define DLET_OPT_DAM 1
`define DLET_OPT_AB 2
`define DLET_OPT_STATIC 3
// Link field
`define DLET_LINK_NULL 16'hffff
`define DLET_LINK_SET_LSB 5
`define DLET_NULL_LINK_WORD 32'h0000ffff
// Quick channel map fields
`define DLET_QMAP_SET_LSB 5
`define DLET_QMAP_WORD_LSB 2
// Register byte offsets
`define DLET_A_LAT_LO 16'h0000
`define DLET_A_LAT_HI 16'h0004
`define DLET_A_ENA_LO 16'h0008
`define DLET_A_ENA_HI 16'h000c
`define DLET_A_SET_LO 16'h0010
`define DLET_A_SET_HI 16'h0014
`define DLET_A_MIS_LO 16'h0018
`define DLET_A_MIS_HI 16'h001c
`define DLET_A_QLAT 16'h0020
`define DLET_A_QENA 16'h0024
`define DLET_A_QMIS 16'h0028
`define DLET_A_STAT 16'h002c
`define DLET_A_QMAP_MSB 16'h0040
`define DLET_A_PMEM_TOP 2'b01
// Fixed audio channels
`define DLET_CH_ATXE 10
`define DLET_CH_ATXO 11
`define DLET_CH_ATXB 12
`define DLET_CH_ARXE 13
`define DLET_CH_ARXO 14
`define DLET_CH_ARXB 15
`endif

//--- logic/dlet_pkg.sv
package dlet_pkg;
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_EVAL = 5'b00010,
        S_SUBMIT = 5'b00100,
        S_UPDATE = 5'b01000,
        S_LINK = 5'b10000
    } dlet_state_e;
    // Transfer described by three counts only
    typedef struct packed {
        logic [6:0] channel;
        logic [15:0] setIndex;
        logic [31:0] option;
        logic [31:0] src;
        logic [31:0] dst;
        logic [15:0] bytesPerArray;
        logic [15:0] arraysPerFrame;
        logic [15:0] framesPerBlock;
    } dlet_trp_s;
endpackage

//--- testbench/dlet_tc_model.sv
`timescale 1ns/10ps
module dlet_tc_model (
    // Clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Request side
    input wire logic trpValid,
    input wire logic slow,
    output logic trpReady,
    // Completion side
    input wire logic chainOn,
    input wire logic [5:0] chainCode,
    output logic tcDone,
    output logic [5:0] tcCode
);
    logic [1:0] waitCnt;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            waitCnt <= 2'h0;
            trpReady <= 1'b0;
            tcDone <= 1'b0;
            tcCode <= 6'h00;
        end else begin
            // Code line toggles outside completions so a stale value is seen
            tcDone <= trpValid && trpReady && chainOn;
            tcCode <= (trpValid && trpReady) ? chainCode : ~tcCode;
            waitCnt <= (trpValid && !trpReady) ? waitCnt + 2'h1 : 2'h0;
            trpReady <= trpValid && !trpReady && (!slow || waitCnt == 2'h3);
        end
    end
endmodule

//--- testbench/testbench.sv
`timescale 1ns/10ps
`include "dlet_cfg.svh"
module testbench;
    typedef struct packed {
        logic [6:0] ch;
        logic [31:0] cnt;
        logic sub;
        logic mis;
    } dlet_row_s;
    logic clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0, rdat, datO;
    logic ack, tcDone, trpValid, trpReady, slow = 1'b0, chainOn = 1'b0;
    logic [63:0] pev = 64'h0;
    logic [5:0] aud = 6'h00, tcCode;
    logic [6:0] lastCh;
    logic [15:0] lastA;
    dlet_pkg::dlet_trp_s transfer_request_packet;
    int miscompares = 0, checked = 0, nTrp = 0, n0;
    dlet_row_s rows [4] = '{'{7'h01, 32'h00010004, 1'b1, 1'b0},
        '{7'h02, 32'h0, 1'b0, 1'b1}, '{7'h05, 32'h00000004, 1'b1, 1'b0},
        '{7'h21, 32'h00010008, 1'b1, 1'b0}};
    always #10 clk = ~clk;
    dlet_core dlet_core_i (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(datO), .wb_ack_o(ack),
        .periphEvent(pev), .audio_tx_even_event(aud[0]),
        .audio_tx_odd_event(aud[1]), .audio_tx_both_event(aud[2]),
        .audio_rx_even_event(aud[3]), .audio_rx_odd_event(aud[4]),
        .audio_rx_both_event(aud[5]), .tcDone(tcDone), .tcCode(tcCode),
        .trpValid(trpValid), .trpReady(trpReady), .transfer_request_packet(transfer_request_packet));
    dlet_tc_model dlet_tc_model_i (.clk(clk), .resetn(resetn),
        .trpValid(trpValid), .slow(slow), .trpReady(trpReady),
        .chainOn(chainOn), .chainCode(6'h28), .tcDone(tcDone),
        .tcCode(tcCode));
    always @(posedge clk) begin
        if (trpValid && trpReady) begin
            nTrp <= nTrp + 1;
            lastCh <= transfer_request_packet.channel;
            lastA <= transfer_request_packet.bytesPerArray;
        end
    end
    task automatic results();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            miscompares++;
            $display("Error t=%0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat} <= {2'b11, w, a, d};
        do @(posedge clk); while (ack !== 1'b1);
        rdat = datO;
        {cyc, stb} <= 2'b00;
    endtask
    function automatic logic [15:0] pa(input int s, input int w);
        return 16'(16'h4000 + s * 32 + w * 4);
    endfunction
    // Word 7 goes last: it is the trigger word of mapped quick sets
    // An all-zero count word also zeroes word 7, giving a null set
    task automatic sp(input int s, input logic [31:0] option_word,
                      input logic [31:0] cnt, input logic [15:0] lnk);
        wb(1'b1, pa(s, 0), option_word);
        wb(1'b1, pa(s, 1), 32'(32'h5a00 + s));
        wb(1'b1, pa(s, 2), cnt);
        wb(1'b1, pa(s, 5), {16'h0000, lnk});
        wb(1'b1, pa(s, 7), 32'(|cnt));
    endtask
    task automatic go(input logic [6:0] ch, input int n);
        n0 = nTrp;
        wb(1'b1, 16'(`DLET_A_SET_LO + {ch[5], 2'b00}), 32'h1 << ch[4:0]);
        for (int i = 0; i < 300 && nTrp < n0 + n; i++) @(posedge clk);
        repeat (6) @(posedge clk);
    endtask
    task automatic hit(input logic [63:0] v, input logic [5:0] a);
        @(posedge clk);
        {pev, aud} <= {v, a};
        @(posedge clk);
        {pev, aud} <= 70'h0;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        results();
    end
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1'b1;
        for (int a = 0; a < 48; a += 8) begin
            wb(1'b0, 16'(a), 32'h0);
            chk(rdat, 32'h0);
        end
        foreach (rows[k]) begin
            sp(rows[k].ch, 32'h0, rows[k].cnt, `DLET_LINK_NULL);
            go(rows[k].ch, 1);
            chk(32'(nTrp - n0), 32'(rows[k].sub));
            if (rows[k].sub) chk(32'(lastCh), 32'(rows[k].ch));
            if (rows[k].sub) chk(32'(lastA), 32'(rows[k].cnt[15:0]));
            wb(1'b0, 16'(`DLET_A_MIS_LO + {rows[k].ch[5], 2'b00}), 32'h0);
            chk(32'(rdat[rows[k].ch[4:0]]), 32'(rows[k].mis));
            wb(1'b1, 16'(`DLET_A_MIS_LO + {rows[k].ch[5], 2'b00}), rdat);
            wb(1'b0, pa(rows[k].ch, 2), 32'h0);
            chk(rdat, 32'h0);
            $display("row %0d done", k);
        end
        slow <= 1'b1;
        sp(100, 32'h0, 32'h00010010, 16'h0c80);
        sp(3, 32'h0, 32'h00010008, 16'h0c80);
        go(7'h03, 1);
        wb(1'b0, pa(3, 1), 32'h0);
        chk(rdat, 32'h00005a64);
        sp(40, 32'h0, 32'h00010004, `DLET_LINK_NULL);
        wb(1'b1, `DLET_A_ENA_HI, 32'h00000100);
        chainOn <= 1'b1;
        go(7'h03, 2);
        chk(32'(nTrp - n0), 32'h2);
        chk(32'(lastCh), 32'h28);
        chainOn <= 1'b0;
        sp(4, 32'h8, 32'h00010004, `DLET_LINK_NULL);
        go(7'h04, 1);
        wb(1'b0, pa(4, 2), 32'h0);
        chk(rdat, 32'h00010004);
        sp(7, 32'h0, 32'h00020004, `DLET_LINK_NULL);
        go(7'h07, 1);
        wb(1'b0, pa(7, 2), 32'h0);
        chk(rdat, 32'h00010004);
        wb(1'b0, pa(7, 7), 32'h0);
        chk(rdat, 32'h00000001);
        $display("link tests done");
        slow <= 1'b0;
        sp(20, 32'h0, 32'h00010004, `DLET_LINK_NULL);
        hit(64'h1 << 20, 6'h00);
        hit(64'h1 << 20, 6'h3f);
        wb(1'b0, `DLET_A_LAT_LO, 32'h0);
        chk(rdat, 32'h0010fc00);
        wb(1'b0, `DLET_A_MIS_LO, 32'h0);
        chk(rdat, 32'h00100000);
        n0 = nTrp;
        wb(1'b1, `DLET_A_ENA_LO, 32'h00100000);
        for (int i = 0; i < 100 && nTrp == n0; i++) @(posedge clk);
        chk(32'(lastCh), 32'h14);
        $display("event tests done");
        wb(1'b1, `DLET_A_QENA, 32'h00000001);
        wb(1'b1, `DLET_A_QMAP_MSB, 32'h0000191c);
        sp(201, 32'h0, 32'h00010004, `DLET_LINK_NULL);
        n0 = nTrp;
        sp(200, 32'h0, 32'h00010004, 16'h1920);
        for (int i = 0; i < 300 && nTrp < n0 + 2; i++) @(posedge clk);
        chk(32'(nTrp - n0), 32'h2);
        chk(32'(lastCh), 32'h40);
        $display("quick tests done");
        results();
    end
endmodule
